// ### pkg/gdl_defs.vh
// Register offsets, field positions, reset values and codes for the gate drive lock bank.
// Assumes inclusion by bare name from the design files under src/.
//
// Contract
// - While locked, writes are ignored except the lock field and control bits 0-2.
// - While unlocked, lock patterns other than 110b leave the lock state unchanged.
// - Writing 011b to bits 10-8 unlocks; the field resets to 011b, unlocked.
// - While locked, lock patterns other than 011b leave registers locked.
// - Source current code at bits 7-4 resets to 1111b; 0000b and 0001b equal lowest.
// - Control bit 0 is a self-clearing fault-clear command pulse.
`ifndef GDL_DEFS_VH
`define GDL_DEFS_VH

// ****************************************
// Register byte addresses (printed index times four)
// ****************************************
`define GDL_IDX_DRV_CTRL 4'h2
`define GDL_IDX_HS_CFG 4'h3
`define GDL_ADDR_FAULT_STAT 12'h004
`define GDL_ADDR_DRV_CTRL 12'h008
`define GDL_ADDR_HS_CFG 12'h00C

// ****************************************
// Field positions and codes
// ****************************************
`define GDL_LOCK_MSB 10
`define GDL_LOCK_LSB 8
`define GDL_CODE_MSB 7
`define GDL_CODE_LSB 4
`define GDL_LOCK_CODE 3'h6
`define GDL_UNLOCK_CODE 3'h3
`define GDL_CODE_RESET 4'hF
`define GDL_LOW_RESET 4'h0
`define GDL_CTRL_RESET 11'h000
`define GDL_CTRL_OPEN_MASK 11'h007

`endif

// ### src/gdl_lock_ctrl.v
// Lock state machine for the register bank.
// Assumes a write strobe and the written lock field from the bus slave, same clock.
`timescale 1ns/1ps
`include "gdl_defs.vh"

module gdl_lock_ctrl (
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    input wire lock_wr,
    input wire [2:0] lock_wdata,
    output reg locked_reg
);
    // ****************************************
    // Lock state
    // ****************************************
    localparam ST_OPEN = 1'b0;
    localparam ST_LOCKED = 1'b1;
    reg locked_next;

    always @* begin
        locked_next = locked_reg;
        case (locked_reg)
            ST_OPEN: begin
                if (lock_wr && lock_wdata == `GDL_LOCK_CODE) begin
                    locked_next = ST_LOCKED;
                end
                // Any other pattern leaves it open
            end
            ST_LOCKED: begin
                if (lock_wr && lock_wdata == `GDL_UNLOCK_CODE) begin
                    locked_next = ST_OPEN;
                end
                // Any other pattern keeps it locked
            end
            default: begin
                locked_next = ST_OPEN;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            locked_reg <= ST_OPEN;
        end else if (clk_en) begin
            locked_reg <= locked_next;
        end
    end
endmodule // gdl_lock_ctrl

// ### src/gdl_reg_bank.v
// Gate drive high-side config and driver control registers over AHB-Lite.
// Assumes one AHB-Lite master on ref_clk; fault inputs are asynchronous levels.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "gdl_defs.vh"

module gdl_reg_bank (
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [10:0] fault_in,
    output reg [3:0] hs_source_current_code,
    output reg [10:0] drv_ctrl_out,
    output reg fault_clear_pulse,
    output reg locked_out
);
    // ****************************************
    // Address phase capture
    // ****************************************
    reg wr_pend_reg;
    reg [11:0] wr_addr_reg;
    reg [10:0] ctrl_reg;
    reg [2:0] lock_field_reg;
    reg [3:0] low_field_reg;
    reg [10:0] fault_meta_reg;
    reg [10:0] fault_sync_reg;
    reg [10:0] fault_lat_reg;
    reg [31:0] rdata_next;
    wire locked;
    wire addr_ok;
    wire wr_hs;
    wire wr_ctrl;
    wire [10:0] ctrl_mask;

    assign addr_ok = hsel && hready && htrans[1];
    assign wr_hs = wr_pend_reg && wr_addr_reg == `GDL_ADDR_HS_CFG;
    assign wr_ctrl = wr_pend_reg && wr_addr_reg == `GDL_ADDR_DRV_CTRL;
    // Locked control writes reach only coast, brake and fault clear
    assign ctrl_mask = locked ? `GDL_CTRL_OPEN_MASK : 11'h7FF;

    gdl_lock_ctrl u_lock (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .lock_wr(wr_hs),
        .lock_wdata(hwdata[`GDL_LOCK_MSB:`GDL_LOCK_LSB]),
        .locked_reg(locked)
    );

    // ****************************************
    // Read mux
    // ****************************************
    always @* begin
        rdata_next = 32'h00000000;
        case (haddr)
            `GDL_ADDR_FAULT_STAT: rdata_next = {21'h0, fault_lat_reg};
            `GDL_ADDR_DRV_CTRL: rdata_next = {21'h0, ctrl_reg};
            `GDL_ADDR_HS_CFG: rdata_next = {21'h0, lock_field_reg, hs_source_current_code, low_field_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ctrl_reg <= `GDL_CTRL_RESET;
            lock_field_reg <= `GDL_UNLOCK_CODE;
            hs_source_current_code <= `GDL_CODE_RESET;
            low_field_reg <= `GDL_LOW_RESET;
            fault_meta_reg <= 11'h000;
            fault_sync_reg <= 11'h000;
            fault_lat_reg <= 11'h000;
            drv_ctrl_out <= `GDL_CTRL_RESET;
            fault_clear_pulse <= 1'b0;
            locked_out <= 1'b0;
        end else if (clk_en) begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr;
            if (addr_ok && !hwrite) begin
                hrdata <= rdata_next;
            end
            fault_meta_reg <= fault_in;
            fault_sync_reg <= fault_meta_reg;
            // Command bit drops back the cycle after it is written
            ctrl_reg[0] <= 1'b0;
            fault_clear_pulse <= 1'b0;
            if (wr_ctrl) begin
                ctrl_reg <= (hwdata[10:0] & ctrl_mask) | (ctrl_reg & ~ctrl_mask);
                ctrl_reg[0] <= hwdata[0];
                fault_clear_pulse <= hwdata[0];
            end
            // New fault wins over a clear in the same cycle
            if (wr_ctrl && hwdata[0]) begin
                fault_lat_reg <= fault_sync_reg;
            end else begin
                fault_lat_reg <= fault_lat_reg | fault_sync_reg;
            end
            if (wr_hs) begin
                lock_field_reg <= hwdata[`GDL_LOCK_MSB:`GDL_LOCK_LSB];
                if (!locked) begin
                    // Codes 0000 and 0001 both give the lowest step; stored as written
                    hs_source_current_code <= hwdata[`GDL_CODE_MSB:`GDL_CODE_LSB];
                    low_field_reg <= hwdata[3:0];
                end
            end
            // Command bit never shows on the level output; it leaves as fault_clear_pulse
            drv_ctrl_out <= wr_ctrl ? {((hwdata[10:1] & ctrl_mask[10:1]) | (ctrl_reg[10:1] & ~ctrl_mask[10:1])), 1'b0}
                : {ctrl_reg[10:1], 1'b0};
            locked_out <= locked;
        end
    end
endmodule // gdl_reg_bank

// ### sim/gdl_reg_bank_assertions.sv
// Checker on the gate drive lock bank ports.
// Assumes gdl_reg_bank on ref_clk with sync active-high rst.
`timescale 1ns/1ps
module gdl_reg_bank_assertions (
    input wire ref_clk,
    input wire rst,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [3:0] hs_source_current_code,
    input wire [10:0] drv_ctrl_out,
    input wire fault_clear_pulse,
    input wire locked_out
);
    // ****
    // Lock history, so a lock in flight is not mistaken for a locked write
    // ****
    reg [1:0] lk_reg;
    always @(posedge ref_clk) lk_reg <= {lk_reg[0], locked_out};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    no_wait_a: assert property (hreadyout) else $error("wait state seen");
    okay_resp_a: assert property (!hresp) else $error("error response seen");
    pulse_once_a: assert property (fault_clear_pulse |=> !fault_clear_pulse) else $error("pulse too long");
    ctrl_bit0_a: assert property (!drv_ctrl_out[0]) else $error("bit0 stuck");
    reset_vals_a: assert property ($fell(rst) |-> hs_source_current_code == 4'hF && !locked_out
        && drv_ctrl_out == 11'h000) else $error("bad reset state");
    code_lock_a: assert property (locked_out && &lk_reg |-> $stable(hs_source_current_code))
        else $error("code moved while locked");
    ctrl_lock_a: assert property (locked_out && &lk_reg |-> $stable(drv_ctrl_out[10:3]))
        else $error("ctrl moved while locked");
    rdata_top_a: assert property (hrdata[31:11] == 21'h0) else $error("upper read bits set");
endmodule // gdl_reg_bank_assertions
bind gdl_reg_bank gdl_reg_bank_assertions u_chk (.*);

// ### sim/gdl_reg_bank_test.sv
// Bench for the gate drive lock bank over AHB-Lite.
// Assumes a zero-wait slave; faults tied inactive.
`timescale 1ns/1ps
`include "gdl_defs.vh"
module gdl_reg_bank_test;
    logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, pulse, locked;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic hready;
    logic [3:0] code;
    logic [10:0] ctrl;
    int n_mismatch = 0, n_compared = 0, cyc = 0, i;
    always #20 ref_clk = ~ref_clk;
    gdl_reg_bank dut (.ref_clk(ref_clk), .rst(rst), .clk_en(1'h1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(), .fault_in(11'h000), .hs_source_current_code(code), .drv_ctrl_out(ctrl),
        .fault_clear_pulse(pulse), .locked_out(locked));
    // ****
    // Bus and check tasks
    // ****
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'h1);
        q = hrdata;
        #1;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            $display("[FAIL] %s exp %h got %h", n, e, s);
            n_mismatch++;
        end
    endtask
    task print_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Ceiling well above the fewer than one hundred cycles the tests take
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            print_verdict;
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'h0;
        xfer(1'h0, `GDL_ADDR_HS_CFG, 32'h0);
        chk("hs", 32'h3F0, q);
        $display("test reset done");
        xfer(1'h1, `GDL_ADDR_HS_CFG, 32'h700);
        #80;
        chk("code", 32'h0, code);
        chk("lock", 32'h0, locked);
        xfer(1'h1, `GDL_ADDR_HS_CFG, 32'h610);
        #80;
        chk("lock", 32'h1, locked);
        xfer(1'h1, `GDL_ADDR_HS_CFG, 32'h7F0);
        xfer(1'h1, `GDL_ADDR_DRV_CTRL, 32'h7FE);
        #80;
        chk("code", 32'h1, code);
        chk("lock", 32'h1, locked);
        chk("ctrl", 32'h6, ctrl);
        xfer(1'h1, `GDL_ADDR_DRV_CTRL, 32'h7);
        for (i = 0; i < 3 && pulse !== 1'h1; i++) #40;
        chk("pulse", 32'h1, pulse);
        #40;
        chk("pulse", 32'h0, pulse);
        $display("test lock done");
        xfer(1'h1, `GDL_ADDR_HS_CFG, 32'h3A0);
        #80;
        chk("lock", 32'h0, locked);
        chk("code", 32'h1, code);
        xfer(1'h1, `GDL_ADDR_HS_CFG, 32'h3A0);
        #80;
        chk("code", 32'hA, code);
        xfer(1'h0, `GDL_ADDR_DRV_CTRL, 32'h0);
        chk("ctrl", 32'h6, q);
        xfer(1'h0, 12'h010, 32'h0);
        chk("hole", 32'h0, q);
        $display("test unlock done");
        print_verdict;
    end
endmodule // gdl_reg_bank_test
